// ---- design/vpcr_pkg.sv ----
package vpcr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus addressing
  localparam logic [7:0] DEV_ADDR_WR   = 8'hDC;
  localparam logic [7:0] DEV_ADDR_RD   = 8'hDD;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] OFS_OFFSET_OVL   = 8'h08;
  localparam logic [7:0] OFS_GLOBAL_CTL   = 8'h09;
  localparam logic [7:0] OFS_ADVANCE_CTL  = 8'h0A;
  localparam logic [7:0] OFS_CLAMP_BLANK  = 8'h0B;
  localparam logic [7:0] OFS_SOFT_RESTORE = 8'h0F;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0] RST_OFFSET_OVL   = 8'h15;
  localparam logic [7:0] RST_GLOBAL_CTL   = 8'h00;
  localparam logic [7:0] RST_ADVANCE_CTL  = 8'h00;
  localparam logic [7:0] RST_CLAMP_BLANK  = 8'h04;
  localparam logic [7:0] RST_SOFT_RESTORE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // writable bits; the rest are reserved and read as zero
  localparam logic [7:0] MSK_OFFSET_OVL   = 8'h1F;
  localparam logic [7:0] MSK_GLOBAL_CTL   = 8'h3F;
  localparam logic [7:0] MSK_ADVANCE_CTL  = 8'h03;
  localparam logic [7:0] MSK_CLAMP_BLANK  = 8'h0F;
  localparam logic [7:0] MSK_SOFT_RESTORE = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned POS_LEVEL_SHIFT    = 0;
  localparam int unsigned POS_OVL_CONTRAST   = 3;
  localparam int unsigned POS_OUTPUT_BLANK   = 0;
  localparam int unsigned POS_SLEEP          = 1;
  localparam int unsigned POS_HALF_RANGE     = 3;
  localparam int unsigned POS_AUX_MIX        = 4;
  localparam int unsigned POS_AUTO_ADV_OFF   = 0;
  localparam int unsigned POS_OVERLAY_ONLY   = 0;
  localparam int unsigned POS_FRAME_BLANK_EN = 1;
  localparam int unsigned POS_AUX_PIN_SEL    = 2;
  localparam int unsigned POS_CLAMP_POL      = 3;
  localparam int unsigned POS_SOFT_RESTORE   = 0;

  ////////////////////////////////////////////////////////////////////////////
  // serial slave states
  typedef enum logic [2:0] {
    VPCR_ST_IDLE  = 3'b000,
    VPCR_ST_ADDR  = 3'b001,
    VPCR_ST_AACK  = 3'b010,
    VPCR_ST_WDATA = 3'b011,
    VPCR_ST_WACK  = 3'b100,
    VPCR_ST_RDATA = 3'b101,
    VPCR_ST_RACK  = 3'b110
  } vpcr_state_t;

endpackage

// ---- design/vpcr_serial_slave.sv ----
`timescale 1ns/100ps
module vpcr_serial_slave (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_oe,
  // register side
  input  wire logic       i_auto_adv_off,
  input  wire logic [7:0] i_rd_data,
  output logic [7:0]      o_ptr,
  output logic            o_wr_stb,
  output logic [7:0]      o_wr_data
);

  typedef struct packed {
    logic [2:0]          scl_s;
    logic [2:0]          sda_s;
    vpcr_pkg::vpcr_state_t st;
    logic [2:0]          bitcnt;
    logic [7:0]          shift;
    logic [7:0]          ptr;
    logic                first;
    logic                byte_done;
    logic                sda_oe;
    logic                wr_stb;
    logic [7:0]          wr_data;
  } vpcr_slv_t;

  vpcr_slv_t q;
  vpcr_slv_t d;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  always_comb begin
    // stage 0 of each synchroniser is read only by stage 1
    scl_rise = q.scl_s[1] & ~q.scl_s[2];
    scl_fall = ~q.scl_s[1] & q.scl_s[2];
    start_c  = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[1] & q.sda_s[2];
    stop_c   = q.scl_s[1] & q.scl_s[2] & q.sda_s[1] & ~q.sda_s[2];
    d        = q;
    d.scl_s  = {q.scl_s[1:0], i_scl};
    d.sda_s  = {q.sda_s[1:0], i_sda};
    d.wr_stb = 1'b0;
    if (start_c) begin
      d.st        = vpcr_pkg::VPCR_ST_ADDR;
      d.bitcnt    = 3'h0;
      d.sda_oe    = 1'b0;
      d.byte_done = 1'b0;
    end else if (stop_c) begin
      d.st     = vpcr_pkg::VPCR_ST_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        vpcr_pkg::VPCR_ST_ADDR, vpcr_pkg::VPCR_ST_WDATA: begin
          if (scl_rise) begin
            d.shift     = {q.shift[6:0], q.sda_s[1]};
            d.bitcnt    = q.bitcnt + 3'h1;
            d.byte_done = (q.bitcnt == 3'h7);
            if (q.bitcnt == 3'h7 && q.st == vpcr_pkg::VPCR_ST_WDATA) begin
              if (q.first) begin
                // first stays set until the ack, so the pointer byte never advances it
                d.ptr = {q.shift[6:0], q.sda_s[1]};
              end else begin
                // data byte takes effect as soon as it is complete
                d.wr_stb  = 1'b1;
                d.wr_data = {q.shift[6:0], q.sda_s[1]};
              end
            end
          end else if (scl_fall && q.byte_done) begin
            // a flag, not the bit count: the fall right after start ends no byte
            d.byte_done = 1'b0;
            if (q.st == vpcr_pkg::VPCR_ST_ADDR) begin
              // only our own address byte is acknowledged
              if (q.shift == vpcr_pkg::DEV_ADDR_WR || q.shift == vpcr_pkg::DEV_ADDR_RD) begin
                d.st     = vpcr_pkg::VPCR_ST_AACK;
                d.sda_oe = 1'b1;
              end else begin
                d.st = vpcr_pkg::VPCR_ST_IDLE;
              end
            end else begin
              d.st     = vpcr_pkg::VPCR_ST_WACK;
              d.sda_oe = 1'b1;
            end
          end
        end
        vpcr_pkg::VPCR_ST_AACK: begin
          if (scl_fall) begin
            if (q.shift[0]) begin
              d.st     = vpcr_pkg::VPCR_ST_RDATA;
              d.shift  = i_rd_data;
              d.sda_oe = ~i_rd_data[7];
            end else begin
              d.st     = vpcr_pkg::VPCR_ST_WDATA;
              d.first  = 1'b1;
              d.sda_oe = 1'b0;
            end
            d.bitcnt = 3'h0;
          end
        end
        vpcr_pkg::VPCR_ST_WACK: begin
          if (scl_fall) begin
            d.st     = vpcr_pkg::VPCR_ST_WDATA;
            d.sda_oe = 1'b0;
            if (q.first) begin
              d.first = 1'b0;
            end else if (!i_auto_adv_off) begin
              // on writes the pointer moves only after a data byte, and only in advance mode
              d.ptr = q.ptr + 8'h01;
            end
          end
        end
        vpcr_pkg::VPCR_ST_RDATA: begin
          if (scl_fall) begin
            d.bitcnt = q.bitcnt + 3'h1;
            if (q.bitcnt == 3'h7) begin
              d.st     = vpcr_pkg::VPCR_ST_RACK;
              d.sda_oe = 1'b0;
              d.ptr    = q.ptr + 8'h01;
            end else begin
              d.shift  = {q.shift[6:0], 1'b0};
              d.sda_oe = ~q.shift[6];
            end
          end
        end
        vpcr_pkg::VPCR_ST_RACK: begin
          if (scl_rise) begin
            d.first = q.sda_s[1];
          end else if (scl_fall) begin
            // a master nack ends the read burst
            if (q.first) begin
              d.st = vpcr_pkg::VPCR_ST_IDLE;
            end else begin
              d.st     = vpcr_pkg::VPCR_ST_RDATA;
              d.shift  = i_rd_data;
              d.sda_oe = ~i_rd_data[7];
              d.bitcnt = 3'h0;
            end
          end
        end
        default: begin
          d.st     = vpcr_pkg::VPCR_ST_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '{scl_s: 3'h7, sda_s: 3'h7, st: vpcr_pkg::VPCR_ST_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign o_sda_oe  = q.sda_oe;
  assign o_ptr     = q.ptr;
  assign o_wr_stb  = q.wr_stb;
  assign o_wr_data = q.wr_data;

endmodule

// ---- design/vpcr_retrace_detect.sv ----
`timescale 1ns/100ps
module vpcr_retrace_detect (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // pins
  input  wire logic i_vblank_pin,
  input  wire logic i_sandcastle_vlevel,
  input  wire logic i_hblank,
  input  wire logic i_clamp,
  // configuration
  input  wire logic i_frame_blank_en,
  input  wire logic i_aux_pin_sel,
  input  wire logic i_clamp_pol,
  // results
  output logic      o_vretrace,
  output logic      o_hblank,
  output logic      o_clamp_active
);

  typedef struct packed {
    logic [1:0] vpin_s;
    logic [1:0] sc_s;
    logic [1:0] hb_s;
    logic [1:0] cl_s;
    logic       vret;
    logic       hb;
    logic       clamp;
  } vpcr_ret_t;

  vpcr_ret_t q;
  vpcr_ret_t d;

  always_comb begin
    d        = q;
    d.vpin_s = {q.vpin_s[0], i_vblank_pin};
    d.sc_s   = {q.sc_s[0], i_sandcastle_vlevel};
    d.hb_s   = {q.hb_s[0], i_hblank};
    d.cl_s   = {q.cl_s[0], i_clamp};
    d.hb     = q.hb_s[1];
    // pin 13 carries vertical blank when the fourth converter is off it
    if (!i_aux_pin_sel) begin
      d.vret = i_frame_blank_en & q.vpin_s[1];
    end else begin
      // both bits set: vertical part is stripped from the sandcastle
      d.vret = i_frame_blank_en & q.sc_s[1];
    end
    d.clamp = q.cl_s[1] ^ i_clamp_pol;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_vretrace     = q.vret;
  assign o_hblank       = q.hb;
  assign o_clamp_active = q.clamp;

endmodule

// ---- design/vpcr_ctrl_regs.sv ----
`timescale 1ns/100ps
module vpcr_ctrl_regs (
  // clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RSTN,
  // serial bus pins
  input  wire logic       I_SCL,
  input  wire logic       I_SDA,
  output logic            O_SDA,
  output logic            O_SDA_OE,
  // timing pins
  input  wire logic       I_VBLANK_PIN,
  input  wire logic       I_SANDCASTLE_VLEVEL,
  input  wire logic       I_HBLANK,
  input  wire logic       I_CLAMP,
  // video controls
  output logic [2:0]      O_VIDEO_LEVEL_SHIFT,
  output logic [1:0]      O_OVERLAY_CONTRAST,
  output logic            O_OUTPUT_BLANK,
  output logic            O_OVERLAY_ONLY,
  output logic            O_RETRACE_BLANK,
  output logic            O_CLAMP_ACTIVE,
  // analog controls
  output logic            O_SLEEP,
  output logic            O_MAIN_HALF_RANGE,
  output logic            O_AUX_MIX,
  output logic            O_AUX_PIN_DRIVE,
  output logic            O_UPDATE_WINDOW,
  output logic            O_SOFT_ABORT
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0] offset_and_overlay_contrast;
    logic [7:0] global_video_control;
    logic [7:0] address_advance_control;
    logic [7:0] clamp_blank_overlay_control;
    logic [1:0] ovl_applied;
    logic [2:0] level_shift;
    logic       out_blank;
    logic       ovl_only;
    logic       retrace_blank;
    logic       clamp_act;
    logic       sleep;
    logic       half_range;
    logic       aux_mix;
    logic       aux_drive;
    logic       upd_win;
    logic       abort;
  } vpcr_regs_t;

  vpcr_regs_t q;
  vpcr_regs_t d;

  logic [7:0] ptr;
  logic       wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic       sda_oe;
  logic       vret;
  logic       hblank;
  logic       clamp_act;
  logic       frame_blank_en;
  logic       upd_ok;

  ////////////////////////////////////////////////////////////////////////////
  // submodules

  vpcr_serial_slave u_slave (
    .i_clk          (I_CLK),
    .i_rstn         (I_RSTN),
    .i_scl          (I_SCL),
    .i_sda          (I_SDA),
    .o_sda_oe       (sda_oe),
    .i_auto_adv_off (q.address_advance_control[vpcr_pkg::POS_AUTO_ADV_OFF]),
    .i_rd_data      (rd_data),
    .o_ptr          (ptr),
    .o_wr_stb       (wr_stb),
    .o_wr_data      (wr_data)
  );

  vpcr_retrace_detect u_retrace (
    .i_clk               (I_CLK),
    .i_rstn              (I_RSTN),
    .i_vblank_pin        (I_VBLANK_PIN),
    .i_sandcastle_vlevel (I_SANDCASTLE_VLEVEL),
    .i_hblank            (I_HBLANK),
    .i_clamp             (I_CLAMP),
    .i_frame_blank_en    (frame_blank_en),
    .i_aux_pin_sel       (q.clamp_blank_overlay_control[vpcr_pkg::POS_AUX_PIN_SEL]),
    .i_clamp_pol         (q.clamp_blank_overlay_control[vpcr_pkg::POS_CLAMP_POL]),
    .o_vretrace          (vret),
    .o_hblank            (hblank),
    .o_clamp_active      (clamp_act)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read side: unmapped offsets and reserved bits read zero

  always_comb begin
    case (ptr)
      vpcr_pkg::OFS_OFFSET_OVL:   rd_data = q.offset_and_overlay_contrast;
      vpcr_pkg::OFS_GLOBAL_CTL:   rd_data = q.global_video_control;
      vpcr_pkg::OFS_ADVANCE_CTL:  rd_data = q.address_advance_control;
      vpcr_pkg::OFS_CLAMP_BLANK:  rd_data = q.clamp_blank_overlay_control;
      default:                    rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // write side and derived controls

  assign frame_blank_en = q.clamp_blank_overlay_control[vpcr_pkg::POS_FRAME_BLANK_EN];
  // host keeps frame_blank_enable low without vertical timing, else no update
  assign upd_ok         = !frame_blank_en || vret;

  always_comb begin
    d       = q;
    d.abort = 1'b0;
    if (wr_stb) begin
      case (ptr)
        vpcr_pkg::OFS_OFFSET_OVL: begin
          d.offset_and_overlay_contrast = wr_data & vpcr_pkg::MSK_OFFSET_OVL;
        end
        vpcr_pkg::OFS_GLOBAL_CTL: begin
          // must-zero bits are stored as written; the host keeps them clear
          d.global_video_control = wr_data & vpcr_pkg::MSK_GLOBAL_CTL;
        end
        vpcr_pkg::OFS_ADVANCE_CTL: begin
          d.address_advance_control = wr_data & vpcr_pkg::MSK_ADVANCE_CTL;
        end
        vpcr_pkg::OFS_CLAMP_BLANK: begin
          // sandcastle use needs clamp_polarity zero, left to the host
          d.clamp_blank_overlay_control = wr_data & vpcr_pkg::MSK_CLAMP_BLANK;
        end
        vpcr_pkg::OFS_SOFT_RESTORE: begin
          if (wr_data[vpcr_pkg::POS_SOFT_RESTORE]) begin
            // the bit never holds: it reloads defaults and reads back zero
            d.offset_and_overlay_contrast = vpcr_pkg::RST_OFFSET_OVL;
            d.global_video_control        = vpcr_pkg::RST_GLOBAL_CTL;
            d.address_advance_control     = vpcr_pkg::RST_ADVANCE_CTL;
            d.clamp_blank_overlay_control = vpcr_pkg::RST_CLAMP_BLANK;
            d.ovl_applied = vpcr_pkg::RST_OFFSET_OVL[vpcr_pkg::POS_OVL_CONTRAST +: 2];
            d.abort       = 1'b1;
          end
        end
        default: begin
          d.abort = 1'b0;
        end
      endcase
    end
    // contrast reaches the output only inside the update window, or at once on a soft restore
    if (upd_ok && !d.abort) begin
      d.ovl_applied = q.offset_and_overlay_contrast[vpcr_pkg::POS_OVL_CONTRAST +: 2];
    end
    d.level_shift   = q.offset_and_overlay_contrast[vpcr_pkg::POS_LEVEL_SHIFT +: 3];
    d.out_blank     = q.global_video_control[vpcr_pkg::POS_OUTPUT_BLANK];
    d.sleep         = q.global_video_control[vpcr_pkg::POS_SLEEP];
    d.half_range    = q.global_video_control[vpcr_pkg::POS_HALF_RANGE];
    d.aux_mix       = q.global_video_control[vpcr_pkg::POS_AUX_MIX];
    d.ovl_only      = q.clamp_blank_overlay_control[vpcr_pkg::POS_OVERLAY_ONLY];
    d.aux_drive     = q.clamp_blank_overlay_control[vpcr_pkg::POS_AUX_PIN_SEL];
    d.retrace_blank = hblank | vret;
    d.clamp_act     = clamp_act;
    d.upd_win       = upd_ok;
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      q <= '{
        offset_and_overlay_contrast: vpcr_pkg::RST_OFFSET_OVL,
        global_video_control:        vpcr_pkg::RST_GLOBAL_CTL,
        address_advance_control:     vpcr_pkg::RST_ADVANCE_CTL,
        clamp_blank_overlay_control: vpcr_pkg::RST_CLAMP_BLANK,
        ovl_applied:   vpcr_pkg::RST_OFFSET_OVL[vpcr_pkg::POS_OVL_CONTRAST +: 2],
        level_shift:   vpcr_pkg::RST_OFFSET_OVL[vpcr_pkg::POS_LEVEL_SHIFT +: 3],
        aux_drive:     vpcr_pkg::RST_CLAMP_BLANK[vpcr_pkg::POS_AUX_PIN_SEL],
        upd_win:       1'b1,
        default:       '0
      };
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops but the constant O_SDA

  // open drain: the line is only ever pulled low
  assign O_SDA               = 1'b0;
  assign O_SDA_OE            = sda_oe;
  assign O_VIDEO_LEVEL_SHIFT = q.level_shift;
  assign O_OVERLAY_CONTRAST  = q.ovl_applied;
  assign O_OUTPUT_BLANK      = q.out_blank;
  assign O_OVERLAY_ONLY      = q.ovl_only;
  assign O_RETRACE_BLANK     = q.retrace_blank;
  assign O_CLAMP_ACTIVE      = q.clamp_act;
  assign O_SLEEP             = q.sleep;
  assign O_MAIN_HALF_RANGE   = q.half_range;
  assign O_AUX_MIX           = q.aux_mix;
  assign O_AUX_PIN_DRIVE     = q.aux_drive;
  assign O_UPDATE_WINDOW     = q.upd_win;
  assign O_SOFT_ABORT        = q.abort;

endmodule

// ---- testbench/vpcr_ctrl_regs_props.sv ----
`timescale 1ns/100ps
module vpcr_ctrl_regs_checker (
  // clock and reset
  input wire logic       I_CLK,
  input wire logic       I_RSTN,
  // inputs
  input wire logic       I_SCL,
  input wire logic       I_VBLANK_PIN,
  input wire logic       I_SANDCASTLE_VLEVEL,
  input wire logic       I_HBLANK,
  // outputs
  input wire logic       O_SDA,
  input wire logic       O_SDA_OE,
  input wire logic [2:0] O_VIDEO_LEVEL_SHIFT,
  input wire logic [1:0] O_OVERLAY_CONTRAST,
  input wire logic       O_OUTPUT_BLANK,
  input wire logic       O_OVERLAY_ONLY,
  input wire logic       O_RETRACE_BLANK,
  input wire logic       O_SLEEP,
  input wire logic       O_AUX_PIN_DRIVE,
  input wire logic       O_UPDATE_WINDOW,
  input wire logic       O_SOFT_ABORT
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  ////////////////////////////////////////
  // eight cycles covers the input synchronisers with margin
  sequence s_hblank_steady;
    I_HBLANK [*8];
  endsequence
  sequence s_timing_quiet;
    (!I_HBLANK && !I_VBLANK_PIN && !I_SANDCASTLE_VLEVEL) [*8];
  endsequence
  sequence s_restore_pulse;
    O_SOFT_ABORT ##1 !O_SOFT_ABORT;
  endsequence
  sequence s_window_shut;
    !O_UPDATE_WINDOW [*3];
  endsequence
  a_sda_low_only: assert property (O_SDA == 1'b0)
    else $error("data pin driven high");
  a_ack_bit_held: assert property ($rose(O_SDA_OE) |-> O_SDA_OE [*8])
    else $error("pull-down shorter than a bit");
  a_oe_scl_low: assert property ($changed(O_SDA_OE) |-> !I_SCL)
    else $error("data changed while bus clock high");
  a_abort_one_cycle: assert property (O_SOFT_ABORT |=> !O_SOFT_ABORT)
    else $error("abort pulse too long");
  a_restore_dflt: assert property (s_restore_pulse |-> ##[0:2] (O_VIDEO_LEVEL_SHIFT == 3'h5 &&
    O_AUX_PIN_DRIVE && O_UPDATE_WINDOW && !O_OUTPUT_BLANK && !O_SLEEP && !O_OVERLAY_ONLY))
    else $error("defaults not restored");
  a_hblank_blanks: assert property (s_hblank_steady |-> O_RETRACE_BLANK)
    else $error("horizontal blank not passed");
  a_quiet_clear: assert property (s_timing_quiet |-> !O_RETRACE_BLANK)
    else $error("blank without any timing input");
  // a soft restore reloads the contrast at once, window or not
  a_contrast_defer: assert property (s_window_shut |->
    $stable(O_OVERLAY_CONTRAST) || O_SOFT_ABORT)
    else $error("contrast moved outside retrace");
endmodule

bind vpcr_ctrl_regs vpcr_ctrl_regs_checker u_props (
  .I_CLK, .I_RSTN, .I_SCL, .I_VBLANK_PIN, .I_SANDCASTLE_VLEVEL, .I_HBLANK, .O_SDA,
  .O_SDA_OE, .O_VIDEO_LEVEL_SHIFT, .O_OVERLAY_CONTRAST, .O_OUTPUT_BLANK, .O_OVERLAY_ONLY,
  .O_RETRACE_BLANK, .O_SLEEP, .O_AUX_PIN_DRIVE, .O_UPDATE_WINDOW, .O_SOFT_ABORT
);

// ---- testbench/vpcr_host_model.sv ----
`timescale 1ns/100ps
module vpcr_host_model (
  // clock
  input  wire logic       i_clk,
  // serial pins
  input  wire logic       i_sda_oe,
  output logic            o_scl,
  output logic            o_sda,
  // results
  output logic [7:0]      o_rd_byte,
  output logic            o_rd_vld,
  output logic [7:0]      o_nack_cnt
);
  logic sda_drv;
  ////////////////////////////////////////
  // pulled-up line: low while either party pulls it
  assign o_sda = sda_drv & ~i_sda_oe;
  initial begin
    o_scl = 1'b1;
    sda_drv = 1'b1;
    o_rd_byte = 8'h00;
    o_rd_vld = 1'b0;
    o_nack_cnt = 8'h00;
  end
  // ten clocks a phase keeps us well clear of the slave's two-flop sampling
  task automatic step(input logic c, input logic d);
    @(negedge i_clk);
    o_scl = c;
    sda_drv = d;
    repeat (9) @(negedge i_clk);
  endtask
  task automatic start();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  task automatic xfer(input logic [7:0] w, input logic ak, output logic [7:0] r, output logic got);
    for (int i = 7; i >= -1; i--) begin
      step(1'b0, sda_drv);
      step(1'b0, (i < 0) ? ak : w[i & 7]);
      step(1'b1, sda_drv);
      if (i >= 0) r[i & 7] = o_sda;
      else got = !o_sda;
    end
  endtask
  task automatic put(input logic [7:0] w);
    logic [7:0] r;
    logic       a;
    xfer(w, 1'b1, r, a);
    if (!a) o_nack_cnt = o_nack_cnt + 8'h01;
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
    start();
    put(vpcr_pkg::DEV_ADDR_WR);
    put(ptr);
    foreach (d[i]) put(d[i]);
    stop();
  endtask
  task automatic rd(input logic [7:0] ptr, input int n);
    logic [7:0] r;
    logic       a;
    start();
    put(vpcr_pkg::DEV_ADDR_WR);
    put(ptr);
    start();
    put(vpcr_pkg::DEV_ADDR_RD);
    for (int i = 0; i < n; i++) begin
      xfer(8'hFF, i == n - 1, r, a);
      o_rd_byte = r;
      o_rd_vld = 1'b1;
      @(negedge i_clk);
      o_rd_vld = 1'b0;
    end
    stop();
  endtask
endmodule

// ---- testbench/vpcr_ctrl_regs_tb_top.sv ----
`timescale 1ns/100ps
`define CHK(e, a) begin compares++; if ((e) !== (a)) begin fails++; \
  $display("ERROR t=%0t exp=%h got=%h", $time, (e), (a)); end end
module vpcr_ctrl_regs_tb_top;
  localparam int LIMIT = 80000;
  logic       clk, rstn, scl, sda, sda_o, sda_oe, frame_blank_enable, sand, hbl, clamp, smp_vld, rd_vld;
  logic       oblank, oonly, rblank, cact, slp, half, mix, aux, win, abort, ak;
  logic [2:0] lvl;
  logic [1:0] con;
  logic [7:0] rd_byte, nacks, smp_val, exp_v, r8, r9, rb, junk;
  logic [7:0] exp_q[$];
  integer     seed, compares, fails, cycles;
  wire  [7:0] vid = {aux, oonly, con, oblank, lvl};
  wire  [7:0] ana = {3'h0, win, mix, half, slp, rblank};
  ////////////////////////////////////////
  vpcr_ctrl_regs u_dut (
    .I_CLK(clk), .I_RSTN(rstn), .I_SCL(scl), .I_SDA(sda), .O_SDA(sda_o), .O_SDA_OE(sda_oe),
    .I_VBLANK_PIN(frame_blank_enable), .I_SANDCASTLE_VLEVEL(sand), .I_HBLANK(hbl), .I_CLAMP(clamp),
    .O_VIDEO_LEVEL_SHIFT(lvl), .O_OVERLAY_CONTRAST(con), .O_OUTPUT_BLANK(oblank),
    .O_OVERLAY_ONLY(oonly), .O_RETRACE_BLANK(rblank), .O_CLAMP_ACTIVE(cact), .O_SLEEP(slp),
    .O_MAIN_HALF_RANGE(half), .O_AUX_MIX(mix), .O_AUX_PIN_DRIVE(aux),
    .O_UPDATE_WINDOW(win), .O_SOFT_ABORT(abort));
  vpcr_host_model u_host (
    .i_clk(clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda), .o_rd_byte(rd_byte),
    .o_rd_vld(rd_vld), .o_nack_cnt(nacks));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic final_report();
    $display("TB: compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      final_report();
    end
  end
  // an empty queue yields unknown, so a stray result always mismatches
  always @(posedge clk) begin
    if (rd_vld || smp_vld) begin
      exp_v = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hXX;
      `CHK(exp_v, (rd_vld ? rd_byte : smp_val))
    end
  end
  task automatic obs(input logic [7:0] e, input logic [7:0] a);
    exp_q.push_back(e);
    @(negedge clk);
    smp_val = a;
    smp_vld = 1'b1;
    @(negedge clk);
    smp_vld = 1'b0;
  endtask
  task automatic rd_exp(input logic [7:0] ptr, input logic [7:0] e[$]);
    foreach (e[i]) exp_q.push_back(e[i]);
    u_host.rd(ptr, e.size());
  endtask
  task automatic settle();
    repeat (12) @(negedge clk);
  endtask
  initial begin
    // seed starts at 86
    {seed, compares, fails, cycles} = {32'h56, 96'h0};
    {rstn, frame_blank_enable, sand, hbl, clamp, smp_vld, smp_val} = 14'h0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    obs(8'hA5, vid);
    obs(8'h10, ana);
    rd_exp(8'h08, '{8'h15, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00});
    for (int i = 0; i < 3; i++) begin
      r8 = 8'($random(seed));
      r9 = 8'($random(seed)) & 8'hDB;
      rb = (8'($random(seed)) | 8'hF0) & 8'hFD;
      u_host.wr(8'h08, '{r8, r9, 8'hFC, rb});
      settle();
      obs({rb[2], rb[0], r8[4:3], r9[0], r8[2:0]}, vid);
      obs({4'h1, r9[4], r9[3], r9[1], 1'b0}, ana);
      rd_exp(8'h08, '{r8 & 8'h1F, r9 & 8'h3F, 8'h00, rb & 8'h0F});
    end
    u_host.wr(8'h0A, '{8'h01});
    u_host.wr(8'h08, '{8'h11, 8'h0A});
    rd_exp(8'h08, '{8'h0A, r9 & 8'h3F, 8'h01});
    u_host.wr(8'h0A, '{8'h00});
    u_host.wr(8'h0C, '{8'h55});
    rd_exp(8'h0C, '{8'h00, 8'h00, 8'h00, 8'h00});
    u_host.start();
    u_host.xfer(8'hA0, 1'b1, junk, ak);
    u_host.stop();
    obs(8'h00, {7'h0, ak});
    // vertical from the aux pin, contrast held until retrace
    u_host.wr(8'h0B, '{8'h02});
    u_host.wr(8'h08, '{8'h1D});
    settle();
    obs(8'h0D, {3'h0, con, lvl});
    frame_blank_enable = 1'b1;
    settle();
    obs(8'h1D, {3'h0, con, lvl});
    obs(8'h03, {6'h0, win, rblank});
    frame_blank_enable = 1'b0;
    settle();
    obs(8'h00, {6'h0, win, rblank});
    u_host.wr(8'h0B, '{8'h06});
    frame_blank_enable = 1'b1;
    settle();
    // converter keeps the aux pin, so its vertical level is not looked at
    obs(8'h04, {5'h0, aux, win, rblank});
    frame_blank_enable = 1'b0;
    sand = 1'b1;
    settle();
    obs(8'h07, {5'h0, aux, win, rblank});
    sand = 1'b0;
    for (int i = 0; i < 4; i++) begin
      u_host.wr(8'h0B, '{{4'h0, i[1], 3'h0}});
      clamp = 1'($random(seed));
      settle();
      obs({7'h0, clamp ^ i[1]}, {7'h0, cact});
    end
    hbl = 1'b1;
    settle();
    obs(8'h03, {6'h0, win, rblank});
    hbl = 1'b0;
    u_host.wr(8'h09, '{8'h1B});
    u_host.wr(8'h0F, '{8'h01});
    settle();
    obs(8'hA5, vid);
    obs(8'h10, ana);
    rd_exp(8'h08, '{8'h15, 8'h00, 8'h00, 8'h04});
    rd_exp(8'h0F, '{8'h00});
    obs(8'h00, nacks);
    repeat (5) @(negedge clk);
    if (exp_q.size() != 0) fails++;
    final_report();
  end
endmodule
